// ==== hw/ms_tick_gen.sv ====
/*
  Millisecond enable pulse from a cycle divider.
  Assumes a synchronous-release reset from the top module.
*/
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int CYCLES = ring_timing_pkg::TICK_CYCLES
) (
  input wire logic clk, // Reference clock
  input wire logic rst_n, // Released reset, active low
  output logic tick // One-cycle pulse each millisecond
);
  localparam int CNT_W = $clog2(CYCLES);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + CNT_W'(1);
    if (cnt_reg == CNT_W'(CYCLES - 1)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  property p_tick_single;
    @(posedge clk) disable iff (!rst_n) tick_reg |=> !tick_reg [*2];
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("ms tick longer than one cycle");
endmodule

// ==== hw/ring_interval_check.sv ====
/*
  Ring frequency check: interval timer loaded on each line event, 2 ms steps.
  Assumes line events are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module ring_interval_check (
  input wire logic clk, // Reference clock
  input wire logic rst_n, // Released reset, active low
  input wire logic enable, // Validation enabled
  input wire logic ms_tick, // Millisecond enable
  input wire logic line_event, // Threshold crossing pulse
  input wire logic [5:0] load_val, // Timer load value
  input wire logic [5:0] limit_val, // Highest allowed timer value at next event
  output logic fail // Pulse: events too close together
);
  localparam int STEP_W = $clog2(ring_timing_pkg::INTERVAL_STEP_MS + 1);
  logic [5:0] timer_reg;
  logic [5:0] timer_next;
  logic [STEP_W-1:0] step_reg;
  logic [STEP_W-1:0] step_next;
  logic armed_reg;
  logic armed_next;
  logic fail_reg;
  logic fail_next;
  logic step;

  always_comb begin
    step = 1'b0;
    step_next = step_reg;
    if (ms_tick) begin
      if (step_reg == STEP_W'(ring_timing_pkg::INTERVAL_STEP_MS - 1)) begin
        step_next = '0;
        step = 1'b1;
      end else begin
        step_next = step_reg + STEP_W'(1);
      end
    end
    timer_next = timer_reg;
    armed_next = armed_reg;
    fail_next = 1'b0;
    if (!enable) begin
      armed_next = 1'b0;
      timer_next = '0;
    end else if (line_event) begin
      fail_next = armed_reg && (timer_reg > limit_val);
      timer_next = load_val;
      armed_next = 1'b1;
    end else if (step && timer_reg != 6'h00) begin
      timer_next = timer_reg - 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= '0;
      step_reg <= '0;
      armed_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      step_reg <= step_next;
      armed_reg <= armed_next;
      fail_reg <= fail_next;
    end
  end

  assign fail = fail_reg;

  property p_too_fast;
    @(posedge clk) disable iff (!rst_n)
      (enable && line_event && armed_reg && timer_reg > limit_val) |=> (fail_reg && timer_reg == $past(load_val));
  endproperty
  a_too_fast: assert property (p_too_fast) else $error("short interval not flagged");
endmodule

// ==== hw/ring_timing_pkg.sv ====
/*
  Constants, field layouts and time codes for the ring validation timing block.
  Assumes a single 20 MHz reference clock and an 8-bit register port.
*/
package ring_timing_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MS_W = 11;
  localparam int FIELD_W = 6;
  localparam int IRQ_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_TIMING = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_LOAD = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h05;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  localparam int DLY_HI_BIT = 7;
  localparam int TMO_LSB = 3;
  localparam int TMO_MSB = 6;
  localparam int CONF_LSB = 0;
  localparam int CONF_MSB = 2;
  localparam int DLY_LO_LSB = 6;
  localparam int DLY_LO_MSB = 7;
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 5;
  localparam int EN_BIT = 7;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int IRQ_VALID_BIT = 0;
  localparam int IRQ_END_BIT = 1;
  localparam int IRQ_FAIL_BIT = 2;

  localparam int DELAY_STEP_SHIFT = 8;
  localparam int TMO_STEP_SHIFT = 7;
  localparam logic [MS_W-1:0] DELAY_MAX_MS = 11'h700;
  localparam logic [MS_W-1:0] TMO_SHORT_MS = 11'h050;
  localparam logic [MS_W-1:0] CONF_MS_0 = 11'h064;
  localparam logic [MS_W-1:0] CONF_MS_1 = 11'h096;
  localparam logic [MS_W-1:0] CONF_MS_2 = 11'h0C8;
  localparam logic [MS_W-1:0] CONF_MS_3 = 11'h100;
  localparam logic [MS_W-1:0] CONF_MS_4 = 11'h180;
  localparam logic [MS_W-1:0] CONF_MS_5 = 11'h200;
  localparam logic [MS_W-1:0] CONF_MS_6 = 11'h280;
  localparam logic [MS_W-1:0] CONF_MS_7 = 11'h400;
  localparam int INTERVAL_STEP_MS = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_CONFIRM, ST_DELAY, ST_VALID} ring_state_t;

  function automatic logic [MS_W-1:0] confirm_ms(input logic [2:0] code);
    case (code)
      3'h0: confirm_ms = CONF_MS_0;
      3'h1: confirm_ms = CONF_MS_1;
      3'h2: confirm_ms = CONF_MS_2;
      3'h3: confirm_ms = CONF_MS_3;
      3'h4: confirm_ms = CONF_MS_4;
      3'h5: confirm_ms = CONF_MS_5;
      3'h6: confirm_ms = CONF_MS_6;
      default: confirm_ms = CONF_MS_7;
    endcase
  endfunction

  function automatic logic [MS_W-1:0] timeout_ms(input logic [3:0] code);
    if (code == 4'h0) begin
      timeout_ms = TMO_SHORT_MS;
    end else begin
      timeout_ms = {code, 7'h00};
    end
  endfunction
endpackage

// ==== hw/ring_validation_timing.sv ====
/*
  Ring validation timing: confirmation, report delay, end-of-ring timeout,
  register port and interrupt. Assumes RING_EVENT_IN is an asynchronous level
  whose rising edge marks a threshold crossing.
*/
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module ring_validation_timing #(
  parameter int TICK_CYCLES = ring_timing_pkg::TICK_CYCLES
) (
  input wire logic REF_CLK, // 20 MHz clock
  input wire logic RESET_N, // Asynchronous reset, active low
  input wire logic RING_EVENT_IN, // Threshold detector level
  input wire logic [7:0] ADDR, // Register address
  input wire logic [7:0] WR_DATA, // Register write data
  input wire logic WR_EN, // Write strobe
  input wire logic RD_EN, // Read strobe
  output logic [7:0] RD_DATA, // Read data, cycle after strobe
  output logic RING_VALID, // Valid ring indication
  output logic IRQ // Level interrupt
);
  logic rst_meta_reg;
  logic rst_n;
  logic ev_meta_reg;
  logic ev_sync_reg;
  logic ev_prev_reg;
  logic line_event;
  logic ms_tick;
  logic freq_fail;

  logic [7:0] timing_reg;
  logic [7:0] timing_next;
  logic [7:0] limit_reg;
  logic [7:0] limit_next;
  logic [7:0] load_reg;
  logic [7:0] load_next;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_mask_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic irq_reg;
  logic irq_next;

  ring_timing_pkg::ring_state_t state_reg;
  ring_timing_pkg::ring_state_t state_next;
  logic [10:0] phase_reg;
  logic [10:0] phase_next;
  logic [10:0] since_reg;
  logic [10:0] since_next;
  logic valid_reg;
  logic valid_next;
  logic [2:0] irq_set;

  logic enable;
  logic [2:0] delay_code;
  logic [10:0] delay_ms;
  logic [10:0] conf_ms;
  logic [10:0] tmo_ms;
  logic ring_over;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta_reg <= 1'b0;
      ev_sync_reg <= 1'b0;
      ev_prev_reg <= 1'b0;
    end else begin
      ev_meta_reg <= RING_EVENT_IN;
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end

  assign line_event = ev_sync_reg && !ev_prev_reg;

  ms_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .tick(ms_tick)
  );

  ring_interval_check u_check (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .enable(enable),
    .ms_tick(ms_tick),
    .line_event(line_event),
    .load_val(load_reg[ring_timing_pkg::FIELD_MSB:ring_timing_pkg::FIELD_LSB]),
    .limit_val(limit_reg[ring_timing_pkg::FIELD_MSB:ring_timing_pkg::FIELD_LSB]),
    .fail(freq_fail)
  );

  // Field decode
  always_comb begin
    enable = load_reg[ring_timing_pkg::EN_BIT];
    delay_code = {timing_reg[ring_timing_pkg::DLY_HI_BIT],
                  limit_reg[ring_timing_pkg::DLY_LO_MSB:ring_timing_pkg::DLY_LO_LSB]};
    delay_ms = {delay_code, 8'h00};
    conf_ms = ring_timing_pkg::confirm_ms(timing_reg[ring_timing_pkg::CONF_MSB:ring_timing_pkg::CONF_LSB]);
    tmo_ms = ring_timing_pkg::timeout_ms(timing_reg[ring_timing_pkg::TMO_MSB:ring_timing_pkg::TMO_LSB]);
    ring_over = (state_reg != ring_timing_pkg::ST_IDLE) && (since_reg >= tmo_ms) && !line_event;
  end

  // Ring sequencer
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    since_next = since_reg;
    irq_set = ring_timing_pkg::IRQ_RESET;
    if (line_event) begin
      since_next = '0;
    end else if (ms_tick && since_reg != 11'h7FF) begin
      since_next = since_reg + 11'h001;
    end
    if (!enable) begin
      state_next = ring_timing_pkg::ST_IDLE;
      phase_next = '0;
    end else if (ring_over) begin
      state_next = ring_timing_pkg::ST_IDLE;
      phase_next = '0;
      irq_set[ring_timing_pkg::IRQ_END_BIT] = (state_reg == ring_timing_pkg::ST_VALID);
    end else begin
      if (freq_fail) begin
        irq_set[ring_timing_pkg::IRQ_FAIL_BIT] = 1'b1;
      end
      case (state_reg)
        ring_timing_pkg::ST_IDLE: begin
          if (line_event) begin
            state_next = ring_timing_pkg::ST_CONFIRM;
            phase_next = '0;
          end
        end
        ring_timing_pkg::ST_CONFIRM: begin
          if (freq_fail) begin
            phase_next = '0;
          end else if (phase_reg >= conf_ms) begin
            phase_next = '0;
            if (delay_code == 3'h0) begin
              state_next = ring_timing_pkg::ST_VALID;
              irq_set[ring_timing_pkg::IRQ_VALID_BIT] = 1'b1;
            end else begin
              state_next = ring_timing_pkg::ST_DELAY;
            end
          end else if (ms_tick) begin
            phase_next = phase_reg + 11'h001;
          end
        end
        ring_timing_pkg::ST_DELAY: begin
          if (freq_fail) begin
            state_next = ring_timing_pkg::ST_CONFIRM;
            phase_next = '0;
          end else if (phase_reg >= delay_ms) begin
            state_next = ring_timing_pkg::ST_VALID;
            phase_next = '0;
            irq_set[ring_timing_pkg::IRQ_VALID_BIT] = 1'b1;
          end else if (ms_tick) begin
            phase_next = phase_reg + 11'h001;
          end
        end
        default: begin
          if (freq_fail) begin
            state_next = ring_timing_pkg::ST_CONFIRM;
            phase_next = '0;
          end
        end
      endcase
    end
    valid_next = (state_next == ring_timing_pkg::ST_VALID);
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ring_timing_pkg::ST_IDLE;
      phase_reg <= '0;
      since_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      since_reg <= since_next;
      valid_reg <= valid_next;
    end
  end

  // Register port and interrupt
  always_comb begin
    timing_next = timing_reg;
    limit_next = limit_reg;
    load_next = load_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg | irq_set;
    rd_data_next = ring_timing_pkg::REG_RESET;
    if (WR_EN) begin
      if (ADDR == ring_timing_pkg::ADDR_TIMING) begin
        timing_next = WR_DATA;
      end else if (ADDR == ring_timing_pkg::ADDR_LIMIT) begin
        limit_next = WR_DATA;
      end else if (ADDR == ring_timing_pkg::ADDR_LOAD) begin
        load_next = WR_DATA;
      end else if (ADDR == ring_timing_pkg::ADDR_IRQ_STAT) begin
        irq_stat_next = (irq_stat_reg & ~WR_DATA[2:0]) | irq_set;
      end else if (ADDR == ring_timing_pkg::ADDR_IRQ_MASK) begin
        irq_mask_next = WR_DATA[2:0];
      end
    end
    if (RD_EN) begin
      if (ADDR == ring_timing_pkg::ADDR_TIMING) begin
        rd_data_next = timing_reg;
      end else if (ADDR == ring_timing_pkg::ADDR_LIMIT) begin
        rd_data_next = limit_reg;
      end else if (ADDR == ring_timing_pkg::ADDR_LOAD) begin
        rd_data_next = {load_reg[7], 1'b0, load_reg[5:0]};
      end else if (ADDR == ring_timing_pkg::ADDR_STATUS) begin
        rd_data_next[ring_timing_pkg::STAT_VALID_BIT] = valid_reg;
        rd_data_next[ring_timing_pkg::STAT_ACTIVE_BIT] = (state_reg != ring_timing_pkg::ST_IDLE);
      end else if (ADDR == ring_timing_pkg::ADDR_IRQ_STAT) begin
        rd_data_next = {5'h00, irq_stat_reg};
      end else if (ADDR == ring_timing_pkg::ADDR_IRQ_MASK) begin
        rd_data_next = {5'h00, irq_mask_reg};
      end
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      timing_reg <= ring_timing_pkg::REG_RESET;
      limit_reg <= ring_timing_pkg::REG_RESET;
      load_reg <= ring_timing_pkg::REG_RESET;
      irq_stat_reg <= ring_timing_pkg::IRQ_RESET;
      irq_mask_reg <= ring_timing_pkg::IRQ_RESET;
      rd_data_reg <= ring_timing_pkg::REG_RESET;
      irq_reg <= 1'b0;
    end else begin
      timing_reg <= timing_next;
      limit_reg <= limit_next;
      load_reg <= load_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rd_data_reg <= rd_data_next;
      irq_reg <= irq_next;
    end
  end

  assign RD_DATA = rd_data_reg;
  assign RING_VALID = valid_reg;
  assign IRQ = irq_reg;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  property p_delay_bound;
    (state_reg == ring_timing_pkg::ST_DELAY) |-> (phase_reg <= ring_timing_pkg::DELAY_MAX_MS);
  endproperty
  a_delay_bound: assert property (p_delay_bound) else $error("report delay beyond limit");

  property p_delay_done;
    (state_reg == ring_timing_pkg::ST_DELAY && enable && !ring_over && !freq_fail && phase_reg >= delay_ms)
      |=> RING_VALID;
  endproperty
  a_delay_done: assert property (p_delay_done) else $error("valid not raised after delay");

  property p_ring_end;
    (state_reg == ring_timing_pkg::ST_VALID && enable && since_reg >= tmo_ms && !line_event)
      |=> (!RING_VALID && state_reg == ring_timing_pkg::ST_IDLE);
  endproperty
  a_ring_end: assert property (p_ring_end) else $error("ring not ended on timeout");

  property p_confirm_full;
    (state_reg == ring_timing_pkg::ST_CONFIRM && state_next != ring_timing_pkg::ST_CONFIRM
      && state_next != ring_timing_pkg::ST_IDLE) |-> (phase_reg >= conf_ms && !freq_fail);
  endproperty
  a_confirm_full: assert property (p_confirm_full) else $error("confirmation cut short");

  property p_confirm_short;
    (state_reg == ring_timing_pkg::ST_CONFIRM && timing_reg[2:0] == 3'h0 && phase_reg < ring_timing_pkg::CONF_MS_0)
      |=> (state_reg != ring_timing_pkg::ST_DELAY && state_reg != ring_timing_pkg::ST_VALID);
  endproperty
  a_confirm_short: assert property (p_confirm_short) else $error("shortest confirmation below 100 ms");

  property p_disabled_idle;
    !enable |=> (state_reg == ring_timing_pkg::ST_IDLE && !RING_VALID);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("timing active while disabled");

  sequence s_fail_in_confirm;
    state_reg == ring_timing_pkg::ST_CONFIRM && enable && !ring_over && freq_fail;
  endsequence
  sequence s_restarted;
    state_reg == ring_timing_pkg::ST_CONFIRM && phase_reg == 11'h000;
  endsequence
  property p_fail_restart;
    s_fail_in_confirm |=> s_restarted;
  endproperty
  a_fail_restart: assert property (p_fail_restart) else $error("confirmation not restarted on failure");
endmodule

// ==== verif/ring_line_model.sv ====
/*
  Line-side partner: threshold detector output for a ringing line.
  Assumes one rising edge per threshold crossing and a low idle output.
*/
`timescale 1ns/1ps
module ring_line_model (
  input wire logic clk, // Reference clock
  input wire logic run, // Ring present on the line
  input wire logic [15:0] half_cyc, // Half crossing period in cycles
  output logic level // Detector output
);
  logic [15:0] cnt;

  // No ring means a quiet detector, so no stray crossings
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 16'h0000;
      level <= 1'b0;
    end else if (cnt >= half_cyc - 16'h0001) begin
      cnt <= 16'h0000;
      level <= ~level;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// ==== verif/test_ring_validation_timing.sv ====
/*
  Self-checking bench for the ring validation timing block.
  Assumes a shortened millisecond tick of 10 cycles and the line model.
*/
`timescale 1ns/1ps
module test_ring_validation_timing;
  localparam int TICK = 10;
  localparam logic [15:0] SLOW = 16'h007D;
  localparam logic [15:0] FAST = 16'h0019;
  localparam int LIMIT = 90000;
  localparam int CONF_TAB [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};
  logic ref_clk;
  logic reset_n;
  logic ring_event;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic ring_valid;
  logic irq;
  logic run;
  logic [15:0] half_cyc;
  logic [7:0] d;
  int n_fail;
  int cmp_count;
  int cyc;
  int t_first;
  int t_last;
  int t_sw;
  bit seen;

  ring_validation_timing #(.TICK_CYCLES(TICK)) uut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .RING_EVENT_IN(ring_event), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .RING_VALID(ring_valid), .IRQ(irq));

  ring_line_model line (.clk(ref_clk), .run(run), .half_cyc(half_cyc), .level(ring_event));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      $display("Error t=%0t got=%h exp=%h", $time, cyc, LIMIT);
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  // Crossing times for the timing measurements
  always @(posedge ring_event) begin
    if (!seen) begin
      t_first = cyc;
    end
    seen = 1'b1;
    t_last = cyc;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic chk_ms(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, lo);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    d = rd_data;
    chk8(d, exp);
  endtask

  task automatic wait_valid(input logic v, input int max_ms);
    int n;
    n = 0;
    while (ring_valid !== v && n < max_ms * TICK) begin
      @(posedge ref_clk);
      n++;
    end
    chk8({7'h00, ring_valid}, {7'h00, v});
  endtask

  task automatic ring_on(input logic [2:0] conf, input logic [2:0] dly, input logic [3:0] tmo);
    int ms;
    int exp;
    wr(ring_timing_pkg::ADDR_TIMING, {dly[2], tmo, conf});
    wr(ring_timing_pkg::ADDR_LIMIT, {dly[1:0], 6'h00});
    seen = 1'b0;
    half_cyc <= SLOW;
    run <= 1'b1;
    wait_valid(1'b1, 2200);
    ms = (cyc - t_first) / TICK;
    exp = CONF_TAB[conf] + 256 * dly;
    chk_ms(ms, exp - 1, exp + 2);
  endtask

  task automatic ring_off(input logic [3:0] tmo);
    int ms;
    int exp;
    run <= 1'b0;
    wait_valid(1'b0, 2000);
    ms = (cyc - t_last) / TICK;
    exp = (tmo == 4'h0) ? 80 : 128 * tmo;
    chk_ms(ms, exp - 1, exp + 2);
  endtask

  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    run = 1'b0;
    half_cyc = SLOW;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Reset values, read-only status and an unmapped place
    wr(8'h06, 8'hFF);
    wr(ring_timing_pkg::ADDR_STATUS, 8'hFF);
    for (int a = 0; a < 7; a++) begin
      rd_chk(a[7:0], 8'h00);
    end
    wr(ring_timing_pkg::ADDR_TIMING, 8'hA5);
    rd_chk(ring_timing_pkg::ADDR_TIMING, 8'hA5);
    wr(ring_timing_pkg::ADDR_LIMIT, 8'h3C);
    rd_chk(ring_timing_pkg::ADDR_LIMIT, 8'h3C);
    wr(ring_timing_pkg::ADDR_IRQ_MASK, 8'hFF);
    rd_chk(ring_timing_pkg::ADDR_IRQ_MASK, 8'h07);
    wr(ring_timing_pkg::ADDR_IRQ_MASK, 8'h00);
    // Ringing while disabled is ignored
    wr(ring_timing_pkg::ADDR_LOAD, 8'h0A);
    run <= 1'b1;
    repeat (150 * TICK) @(posedge ref_clk);
    chk8({7'h00, ring_valid}, 8'h00);
    rd_chk(ring_timing_pkg::ADDR_STATUS, 8'h00);
    run <= 1'b0;
    wr(ring_timing_pkg::ADDR_LOAD, 8'hCA);
    rd_chk(ring_timing_pkg::ADDR_LOAD, 8'h8A);
    // Every confirmation code, shortest end timeout
    for (int c = 0; c < 8; c++) begin
      ring_on(c[2:0], 3'h0, 4'h0);
      ring_off(4'h0);
    end
    // Report delay with valid and end interrupts
    wr(ring_timing_pkg::ADDR_IRQ_STAT, 8'h07);
    wr(ring_timing_pkg::ADDR_IRQ_MASK, 8'h03);
    ring_on(3'h0, 3'h2, 4'h1);
    rd_chk(ring_timing_pkg::ADDR_STATUS, 8'h03);
    chk8({7'h00, irq}, 8'h01);
    rd_chk(ring_timing_pkg::ADDR_IRQ_STAT, 8'h01);
    wr(ring_timing_pkg::ADDR_IRQ_STAT, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk8({7'h00, irq}, 8'h00);
    ring_off(4'h1);
    repeat (2) @(posedge ref_clk);
    chk8({7'h00, irq}, 8'h01);
    rd_chk(ring_timing_pkg::ADDR_IRQ_STAT, 8'h02);
    wr(ring_timing_pkg::ADDR_IRQ_STAT, 8'h02);
    repeat (2) @(posedge ref_clk);
    chk8({7'h00, irq}, 8'h00);
    // Longest delay, then disable in mid-ring
    wr(ring_timing_pkg::ADDR_IRQ_MASK, 8'h00);
    ring_on(3'h0, 3'h7, 4'h2);
    wr(ring_timing_pkg::ADDR_LOAD, 8'h0A);
    repeat (2) @(posedge ref_clk);
    chk8({7'h00, ring_valid}, 8'h00);
    run <= 1'b0;
    wr(ring_timing_pkg::ADDR_LOAD, 8'hCA);
    wr(ring_timing_pkg::ADDR_IRQ_STAT, 8'h07);
    // Too-fast ring fails and restarts confirmation
    // Limit 4: a 5 ms interval fails, the 15 ms one at the rate change passes
    wr(ring_timing_pkg::ADDR_TIMING, 8'h00);
    wr(ring_timing_pkg::ADDR_LIMIT, 8'h04);
    half_cyc <= FAST;
    run <= 1'b1;
    repeat (150 * TICK) @(posedge ref_clk);
    chk8({7'h00, ring_valid}, 8'h00);
    rd_chk(ring_timing_pkg::ADDR_IRQ_STAT, 8'h04);
    chk8({7'h00, irq}, 8'h00);
    wr(ring_timing_pkg::ADDR_IRQ_MASK, 8'h04);
    repeat (2) @(posedge ref_clk);
    chk8({7'h00, irq}, 8'h01);
    t_sw = cyc;
    half_cyc <= SLOW;
    wait_valid(1'b1, 300);
    chk_ms((cyc - t_sw) / TICK, 94, 102);
    wr(ring_timing_pkg::ADDR_IRQ_STAT, 8'h07);
    repeat (2) @(posedge ref_clk);
    chk8({7'h00, irq}, 8'h00);
    ring_off(4'h0);
    give_verdict();
  end
endmodule
